//--- verilog/tfc_defs.svh
// Purpose: constants of the timer output flip-flop control block
// Assumes: included by bare name from the design files
// Notes:   offsets are byte addresses on the plain register port
`ifndef TFC_DEFS_SVH
`define TFC_DEFS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define TFC_ADDR_W              32
`define TFC_ADDR_SEL_HI         32'h0080_0223
`define TFC_ADDR_PROT_LO        32'h0080_0224
`define TFC_ADDR_DATA_LO        32'h0080_0226
`define TFC_ADDR_PROT_HI        32'h0080_0229
`define TFC_ADDR_DATA_HI        32'h0080_022B

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TFC_RST_PROT_LO         16'h0000
`define TFC_RST_PROT_HI         5'h00
`define TFC_RST_SEL_HI          8'h00
`define TFC_RST_FF              1'h0

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define TFC_NUM_FF              21
`define TFC_NUM_LO              16
`define TFC_NUM_HI              5
`define TFC_HI_FIELD_W          5
`define TFC_SEL19_POS           6
`define TFC_SEL18_POS           4
`define TFC_SEL17_POS           2
`define TFC_SEL16_POS           0
`define TFC_SEL_W               2

// ----------------------------------------------------------------
// selector codes
// ----------------------------------------------------------------
`define TFC_SEL3_BUS0           2'h2
`define TFC_SEL3_BUS1           2'h3
`define TFC_SEL16_TMR           2'h0
`define TFC_SEL16_BUS0          2'h1
`define TFC_SEL16_BUS1          2'h2
`define TFC_SEL16_BUS3          2'h3

`endif

//--- verilog/tfc_pkg.sv
// Purpose: types of the timer output flip-flop control block
// Assumes: nothing
// Notes:   all state of each module is one packed struct
package tfc_pkg;

    // ------------------------------------------------------------
    // register file state of the top module
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] prot_lo_ff;
        logic [4:0]  prot_hi_ff;
        logic [7:0]  sel_hi_ff;
        logic [15:0] rdata_ff;
    } tfc_regs_s;

    // ------------------------------------------------------------
    // state of one output flip-flop cell
    // ------------------------------------------------------------
    typedef struct packed {
        logic q_ff;
    } tfc_cell_s;

endpackage

//--- verilog/tfc_ff_cell.sv
// Purpose: one timer output flip-flop with software force
// Assumes: evt and wr_en are one-cycle pulses on ref_clk
// Notes:   a software write wins over a timer event
`timescale 1ns/1ps
`default_nettype none
`include "tfc_defs.svh"

module tfc_ff_cell (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // timer event and software force
    input  wire logic evt,
    input  wire logic wr_en,
    input  wire logic wr_val,
    // flip-flop output
    output logic      q
);

    tfc_pkg::tfc_cell_s st_ff;
    tfc_pkg::tfc_cell_s nxt_st;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (wr_en) begin
            nxt_st.q_ff = wr_val;
        end else if (evt) begin
            nxt_st.q_ff = ~st_ff.q_ff;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff.q_ff <= `TFC_RST_FF;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q_ff;

endmodule
`default_nettype wire

//--- verilog/tfc_top.sv
// Purpose: timer output flip-flop control: sources, protect, data
// Assumes: all inputs synchronous to ref_clk; events are pulses
// Notes:   read data stand in the cycle after the read strobe
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tfc_defs.svh"

module tfc_top #(
    parameter int NUM_FF = `TFC_NUM_FF
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    // register port
    input  wire logic [`TFC_ADDR_W-1:0] reg_addr,
    input  wire logic [15:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [15:0]            reg_rdata,
    // timer sources, one-cycle pulses
    input  wire logic [15:0]            src_lo_evt,
    input  wire logic                   src_ch20_evt,
    input  wire logic                   io_timer_channel_5,
    input  wire logic                   io_timer_channel_6,
    input  wire logic                   io_timer_channel_7,
    input  wire logic                   io_timer_channel_8,
    // output event bus lines, one-cycle pulses
    input  wire logic [3:0]             evt_bus,
    // flip-flop outputs
    output logic      [NUM_FF-1:0]      ff_out
);

    tfc_pkg::tfc_regs_s st_ff;
    tfc_pkg::tfc_regs_s nxt_st;

    logic [NUM_FF-1:0] ff_q;
    logic [NUM_FF-1:0] ff_evt;
    logic [NUM_FF-1:0] ff_wr_en;
    logic [NUM_FF-1:0] ff_wr_val;
    logic [NUM_FF-1:0] ff_prot;
    logic [1:0]        sel16;
    logic [1:0]        sel17;
    logic [1:0]        sel18;
    logic [1:0]        sel19;
    logic              hit_sel_hi;
    logic              hit_prot_lo;
    logic              hit_data_lo;
    logic              hit_prot_hi;
    logic              hit_data_hi;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    assign hit_sel_hi  = (reg_addr == `TFC_ADDR_SEL_HI);
    assign hit_prot_lo = (reg_addr == `TFC_ADDR_PROT_LO);
    assign hit_data_lo = (reg_addr == `TFC_ADDR_DATA_LO);
    assign hit_prot_hi = (reg_addr == `TFC_ADDR_PROT_HI);
    assign hit_data_hi = (reg_addr == `TFC_ADDR_DATA_HI);

    // ------------------------------------------------------------
    // selector fields
    // ------------------------------------------------------------
    assign sel19 = st_ff.sel_hi_ff[`TFC_SEL19_POS +: `TFC_SEL_W];
    assign sel18 = st_ff.sel_hi_ff[`TFC_SEL18_POS +: `TFC_SEL_W];
    assign sel17 = st_ff.sel_hi_ff[`TFC_SEL17_POS +: `TFC_SEL_W];
    assign sel16 = st_ff.sel_hi_ff[`TFC_SEL16_POS +: `TFC_SEL_W];

    // three-way selector: 0X timer, 10 bus 0, 11 bus 1
    function automatic logic pick3(input logic [1:0] sel, input logic tmr,
                                   input logic [3:0] bus);
        logic r;
        r = tmr;
        case (sel)
            `TFC_SEL3_BUS0: r = bus[0];
            `TFC_SEL3_BUS1: r = bus[1];
            default:        r = tmr;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    always_comb begin
        ff_evt                  = '0;
        ff_evt[`TFC_NUM_LO-1:0] = src_lo_evt;
        ff_evt[NUM_FF-1]        = src_ch20_evt;
        ff_evt[19]              = pick3(sel19, io_timer_channel_8, evt_bus);
        ff_evt[18]              = pick3(sel18, io_timer_channel_7, evt_bus);
        ff_evt[17]              = pick3(sel17, io_timer_channel_6, evt_bus);
        case (sel16)
            `TFC_SEL16_TMR:  ff_evt[16] = io_timer_channel_5;
            `TFC_SEL16_BUS0: ff_evt[16] = evt_bus[0];
            `TFC_SEL16_BUS1: ff_evt[16] = evt_bus[1];
            `TFC_SEL16_BUS3: ff_evt[16] = evt_bus[3];
            default:         ff_evt[16] = io_timer_channel_5;
        endcase
    end

    // ------------------------------------------------------------
    // protected software writes
    // ------------------------------------------------------------
    assign ff_prot = {st_ff.prot_hi_ff, st_ff.prot_lo_ff};

    always_comb begin
        ff_wr_en  = '0;
        ff_wr_val = '0;
        ff_wr_val[`TFC_NUM_LO-1:0] = reg_wdata;
        ff_wr_val[NUM_FF-1:`TFC_NUM_LO] = reg_wdata[`TFC_HI_FIELD_W-1:0];
        if (reg_wr && hit_data_lo) begin
            ff_wr_en[`TFC_NUM_LO-1:0] = ~ff_prot[`TFC_NUM_LO-1:0];
        end
        if (reg_wr && hit_data_hi) begin
            ff_wr_en[NUM_FF-1:`TFC_NUM_LO] = ~ff_prot[NUM_FF-1:`TFC_NUM_LO];
        end
    end

    // ------------------------------------------------------------
    // output flip-flops
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FF; gi++) begin : g_cell
            tfc_ff_cell u_cell (
                .ref_clk (ref_clk),
                .rst_b   (rst_b),
                .evt     (ff_evt[gi]),
                .wr_en   (ff_wr_en[gi]),
                .wr_val  (ff_wr_val[gi]),
                .q       (ff_q[gi])
            );
        end
    endgenerate

    assign ff_out = ff_q;

    // ------------------------------------------------------------
    // register writes and read data
    // ------------------------------------------------------------
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.rdata_ff = 16'h0000;
        if (reg_wr) begin
            if (hit_sel_hi) begin
                nxt_st.sel_hi_ff = reg_wdata[7:0];
            end
            if (hit_prot_lo) begin
                nxt_st.prot_lo_ff = reg_wdata;
            end
            if (hit_prot_hi) begin
                nxt_st.prot_hi_ff = reg_wdata[`TFC_HI_FIELD_W-1:0];
            end
        end
        if (reg_rd) begin
            if (hit_sel_hi) begin
                nxt_st.rdata_ff = {8'h00, st_ff.sel_hi_ff};
            end else if (hit_prot_lo) begin
                nxt_st.rdata_ff = st_ff.prot_lo_ff;
            end else if (hit_data_lo) begin
                nxt_st.rdata_ff = ff_q[`TFC_NUM_LO-1:0];
            end else if (hit_prot_hi) begin
                nxt_st.rdata_ff = {11'h000, st_ff.prot_hi_ff};
            end else if (hit_data_hi) begin
                nxt_st.rdata_ff = {11'h000, ff_q[NUM_FF-1:`TFC_NUM_LO]};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff.prot_lo_ff <= `TFC_RST_PROT_LO;
            st_ff.prot_hi_ff <= `TFC_RST_PROT_HI;
            st_ff.sel_hi_ff  <= `TFC_RST_SEL_HI;
            st_ff.rdata_ff   <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata_ff;

endmodule
`default_nettype wire

//--- testbench/tfc_evt_src.sv
// Purpose: timer and event bus pulse source
// Assumes: pattern given by the bench
// Notes:   a high bit is one pulse in that cycle
`timescale 1ns/1ps
`default_nettype none
module tfc_evt_src (
    // clock and control
    input  wire logic        ref_clk,
    input  wire logic        en,
    input  wire logic [24:0] pat,
    // pulses, tmr_evt is channels 8..5
    output logic      [15:0] src_lo_evt,
    output logic             src_ch20_evt,
    output logic      [3:0]  tmr_evt,
    output logic      [3:0]  evt_bus
);
    always @(posedge ref_clk) begin
        {evt_bus, tmr_evt, src_ch20_evt, src_lo_evt} <= en ? pat : 25'h0000000;
    end
endmodule
`default_nettype wire

//--- testbench/tfc_top_props.sv
// Purpose: port checks of tfc_top
// Assumes: one clock domain
// Notes:   protect and select mirrored from writes
`timescale 1ns/1ps
`default_nettype none
`include "tfc_defs.svh"
module tfc_top_props #(parameter int NUM_FF = 21) (
    // clock and reset
    input wire logic                   ref_clk,
    input wire logic                   rst_b,
    // register port
    input wire logic [`TFC_ADDR_W-1:0] reg_addr,
    input wire logic [15:0]            reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire logic [15:0]            reg_rdata,
    // sources
    input wire logic [15:0]            src_lo_evt,
    input wire logic                   src_ch20_evt,
    input wire logic                   io_timer_channel_5,
    input wire logic                   io_timer_channel_6,
    input wire logic                   io_timer_channel_7,
    input wire logic                   io_timer_channel_8,
    input wire logic [3:0]             evt_bus,
    // outputs
    input wire logic [NUM_FF-1:0]      ff_out
);
    logic [20:0] prot_ff;
    logic [7:0]  sel_ff;
    logic [20:16] ev;
    logic wlo;
    logic whi;
    assign wlo = reg_wr && reg_addr == `TFC_ADDR_DATA_LO;
    assign whi = reg_wr && reg_addr == `TFC_ADDR_DATA_HI;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prot_ff <= '0;
            sel_ff <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `TFC_ADDR_PROT_LO) prot_ff[15:0] <= reg_wdata;
            if (reg_addr == `TFC_ADDR_PROT_HI) prot_ff[20:16] <= reg_wdata[4:0];
            if (reg_addr == `TFC_ADDR_SEL_HI) sel_ff <= reg_wdata[7:0];
        end
    end
    always_comb begin
        ev[20] = src_ch20_evt;
        ev[19] = sel_ff[7] ? evt_bus[sel_ff[6]] : io_timer_channel_8;
        ev[18] = sel_ff[5] ? evt_bus[sel_ff[4]] : io_timer_channel_7;
        ev[17] = sel_ff[3] ? evt_bus[sel_ff[2]] : io_timer_channel_6;
        ev[16] = (sel_ff[1:0] == 2'h0) ? io_timer_channel_5
                                        : evt_bus[{sel_ff[1] & sel_ff[0], sel_ff[1]}];
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_rd_dhi; reg_rd && reg_addr == `TFC_ADDR_DATA_HI; endsequence
    sequence s_rd_phi; reg_rd && reg_addr == `TFC_ADDR_PROT_HI; endsequence
    property p_dhi_unused; s_rd_dhi ##1 1'b1 |-> reg_rdata[15:5] == 11'h000; endproperty
    property p_phi_unused; s_rd_phi ##1 1'b1 |-> reg_rdata[15:5] == 11'h000; endproperty
    property p_force_lo;
        wlo |=> ((ff_out[15:0] ^ $past(reg_wdata)) & ~$past(prot_ff[15:0])) == 16'h0000;
    endproperty
    property p_block_lo;
        wlo |=> ((ff_out[15:0] ^ $past(ff_out[15:0]) ^ $past(src_lo_evt))
                 & $past(prot_ff[15:0])) == 16'h0000;
    endproperty
    property p_force_hi;
        whi |=> ((ff_out[20:16] ^ $past(reg_wdata[4:0])) & ~$past(prot_ff[20:16])) == 5'h00;
    endproperty
    property p_block_hi;
        whi |=> ((ff_out[20:16] ^ $past(ff_out[20:16]) ^ $past(ev)) & $past(prot_ff[20:16]))
                == 5'h00;
    endproperty
    property p_follow_lo; !wlo |=> ff_out[15:0] == ($past(ff_out[15:0]) ^ $past(src_lo_evt));
    endproperty
    property p_follow_hi; !whi |=> ff_out[20:16] == ($past(ff_out[20:16]) ^ $past(ev));
    endproperty
    a_dhi_unused: assert property (p_dhi_unused) else $error("data high unused bits");
    a_phi_unused: assert property (p_phi_unused) else $error("protect high unused");
    a_force_lo: assert property (p_force_lo) else $error("low force");
    a_block_lo: assert property (p_block_lo) else $error("low block");
    a_force_hi: assert property (p_force_hi) else $error("high force");
    a_block_hi: assert property (p_block_hi) else $error("high block");
    a_follow_lo: assert property (p_follow_lo) else $error("low follow");
    a_follow_hi: assert property (p_follow_hi) else $error("high src");
endmodule
bind tfc_top tfc_top_props #(.NUM_FF(NUM_FF)) u_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_lo_evt(src_lo_evt), .src_ch20_evt(src_ch20_evt),
    .io_timer_channel_5(io_timer_channel_5), .io_timer_channel_6(io_timer_channel_6),
    .io_timer_channel_7(io_timer_channel_7), .io_timer_channel_8(io_timer_channel_8),
    .evt_bus(evt_bus), .ff_out(ff_out));
`default_nettype wire

//--- testbench/test_timer_output_flipflop_control.sv
// Purpose: self-checking bench of tfc_top
// Assumes: random pulses from tfc_evt_src
// Notes:   model checked every cycle
`timescale 1ns/1ps
`default_nettype none
`include "tfc_defs.svh"
module test_timer_output_flipflop_control;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [31:0] reg_addr = 32'h00000000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, slo, erd;
    logic [3:0] tmr, ebus;
    logic s20;
    logic en = 1'b0;
    logic [24:0] pat = 25'h0000000;
    logic [20:0] ff_out, ef, pf, ev;
    logic [7:0] sf;
    logic [31:0] r;
    int n_fail = 0, compares = 0, seed = 80, i, k;
    logic [31:0] amap [8] = '{`TFC_ADDR_SEL_HI, `TFC_ADDR_PROT_LO, `TFC_ADDR_DATA_LO,
        `TFC_ADDR_PROT_HI, `TFC_ADDR_DATA_HI, 32'h0080_0225, 32'h0080_0228, 32'h0080_022A};
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) pat <= 25'($random(seed));
    tfc_evt_src u_src (.ref_clk(ref_clk), .en(en), .pat(pat), .src_lo_evt(slo),
        .src_ch20_evt(s20), .tmr_evt(tmr), .evt_bus(ebus));
    tfc_top DUT (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_lo_evt(slo),
        .src_ch20_evt(s20), .io_timer_channel_5(tmr[0]), .io_timer_channel_6(tmr[1]),
        .io_timer_channel_7(tmr[2]), .io_timer_channel_8(tmr[3]), .evt_bus(ebus),
        .ff_out(ff_out));
    // model of registers and flip-flops
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ef = '0; pf = '0; sf = '0; erd = '0;
        end else begin
            ev = {s20, 4'h0, slo};
            ev[19] = sf[7] ? ebus[sf[6]] : tmr[3];
            ev[18] = sf[5] ? ebus[sf[4]] : tmr[2];
            ev[17] = sf[3] ? ebus[sf[2]] : tmr[1];
            ev[16] = (sf[1:0] == 2'h0) ? tmr[0] : ebus[(sf[1:0] == 2'h3) ? 3 : sf[1:0] - 1];
            erd = 16'h0000;
            if (reg_rd) case (reg_addr)
                `TFC_ADDR_SEL_HI: erd = {8'h00, sf};
                `TFC_ADDR_PROT_LO: erd = pf[15:0];
                `TFC_ADDR_DATA_LO: erd = ef[15:0];
                `TFC_ADDR_PROT_HI: erd = {11'h000, pf[20:16]};
                `TFC_ADDR_DATA_HI: erd = {11'h000, ef[20:16]};
                default: erd = 16'h0000;
            endcase
            ef = ef ^ ev;
            if (reg_wr) case (reg_addr)
                `TFC_ADDR_SEL_HI: sf = reg_wdata[7:0];
                `TFC_ADDR_PROT_LO: pf[15:0] = reg_wdata;
                `TFC_ADDR_PROT_HI: pf[20:16] = reg_wdata[4:0];
                `TFC_ADDR_DATA_LO: ef[15:0] = ef[15:0] & pf[15:0] | reg_wdata & ~pf[15:0];
                `TFC_ADDR_DATA_HI: ef[20:16] = ef[20:16] & pf[20:16] | reg_wdata[4:0] & ~pf[20:16];
                default: ;
            endcase
        end
    end
    always @(negedge ref_clk) if (rst_b) begin
        compares += 2;
        if (ff_out !== ef) begin
            n_fail++;
            $display("mismatch %0t ff_out %h exp %h", $time, ff_out, ef);
        end
        if (reg_rdata !== erd) begin
            n_fail++;
            $display("mismatch %0t rdata %h exp %h", $time, reg_rdata, erd);
        end
    end
    task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= w;
        reg_rd <= ~w;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic idle();
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic results();
        if (n_fail == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        results();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (i = 0; i < 8; i++) acc(1'b0, amap[i], 16'h0000);
        for (k = 0; k < 4; k++) begin
            acc(1'b1, `TFC_ADDR_SEL_HI, {8'h00, {4{k[1:0]}}});
            acc(1'b0, `TFC_ADDR_SEL_HI, 16'h0000);
            idle();
            en <= 1'b1;
            repeat (20) @(posedge ref_clk);
            en <= 1'b0;
        end
        en <= 1'b1;
        for (i = 0; i < 200; i++) begin
            r = $random(seed);
            acc(1'b1, amap[r[2:0]], r[31:16]);
            acc(1'b0, amap[r[5:3]], 16'h0000);
        end
        idle();
        en <= 1'b0;
        repeat (3) @(posedge ref_clk);
        results();
    end
endmodule
`default_nettype wire
